// ### apc_pkg.sv
// Shared constants for the attribute palette controller
package apc_pkg;

  // Host I/O ports
  localparam logic [15:0] APC_PORT_WR     = 16'h03C0;
  localparam logic [15:0] APC_PORT_RD     = 16'h03C1;
  localparam logic [15:0] APC_PORT_STAT_M = 16'h03BA;
  localparam logic [15:0] APC_PORT_STAT_C = 16'h03DA;

  // Data register indexes
  localparam logic [4:0] APC_IDX_PAL_LAST = 5'h0F;
  localparam logic [4:0] APC_IDX_MODE     = 5'h10;
  localparam logic [4:0] APC_IDX_BORDER   = 5'h11;
  localparam logic [4:0] APC_IDX_PLANE    = 5'h12;
  localparam logic [4:0] APC_IDX_SHIFT    = 5'h13;
  localparam logic [4:0] APC_IDX_CSEL     = 5'h14;

  // Index register fields
  localparam int APC_IDX_PAS_BIT = 5;

  // Mode control fields
  localparam int APC_MODE_C54_BIT   = 7;
  localparam int APC_MODE_WIDE_BIT  = 6;
  localparam int APC_MODE_PANC_BIT  = 5;
  localparam int APC_MODE_BLINK_BIT = 3;
  localparam int APC_MODE_LGFX_BIT  = 2;
  localparam int APC_MODE_GFX_BIT   = 0;

  // Writable bit masks (reserved bits read zero)
  localparam logic [7:0] APC_MASK_INDEX = 8'h3F;
  localparam logic [7:0] APC_MASK_PAL   = 8'h3F;
  localparam logic [7:0] APC_MASK_MODE  = 8'hEF;
  localparam logic [7:0] APC_MASK_PLANE = 8'h3F;
  localparam logic [7:0] APC_MASK_SHIFT = 8'h0F;
  localparam logic [7:0] APC_MASK_CSEL  = 8'h0F;

  // Values after reset
  localparam logic [7:0] APC_RST_REG    = 8'h00;
  localparam logic [7:0] APC_RST_PLANE  = 8'h0F;
  localparam logic       APC_RST_TOGGLE = 1'b0;

  // Panning
  localparam logic [3:0] APC_PAN_NINE_WRAP = 4'h8;

  // Status-digit codes
  localparam logic [3:0] APC_DIGIT_MONO  = 4'hB;
  localparam logic [3:0] APC_DIGIT_COLOR = 4'hD;

  // Status route selections
  typedef enum logic [1:0] {
    APC_RT_20 = 2'b00,
    APC_RT_54 = 2'b01,
    APC_RT_31 = 2'b10,
    APC_RT_76 = 2'b11
  } apc_route_t;

endpackage : apc_pkg

// ### apc_skid2.sv
// Two-entry buffer with registered valid/ready on both sides
`timescale 1ns/1ps
module apc_skid2 #(
  parameter int W = 8
) (
  input  wire logic         i_clk,       // Dot clock
  input  wire logic         i_nrst,      // Async reset, low
  input  wire logic         i_in_valid,  // Word offered
  input  wire logic [W-1:0] i_in_data,   // Word
  output logic              o_in_ready,  // Room for a word
  output logic              o_out_valid, // Word available
  output logic [W-1:0]      o_out_data,  // Head word
  input  wire logic         i_out_ready  // Receiver takes word
);

  logic [W-1:0] spare_r;
  logic         spare_v_r;
  logic         push;
  logic         pop;
  logic         spare_v_nxt;

  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;

  always_comb begin
    spare_v_nxt = spare_v_r;
    if (!o_out_valid || pop) begin
      spare_v_nxt = spare_v_r & push;
    end else if (push) begin
      spare_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
      spare_r     <= '0;
      spare_v_r   <= 1'b0;
      o_in_ready  <= 1'b1;
    end else begin
      if (!o_out_valid || pop) begin
        o_out_valid <= spare_v_r | push;
        o_out_data  <= spare_v_r ? spare_r : i_in_data;
        if (spare_v_r && push) begin
          spare_r <= i_in_data;
        end
      end else if (push) begin
        spare_r <= i_in_data;
      end
      spare_v_r  <= spare_v_nxt;
      o_in_ready <= ~spare_v_nxt;
    end
  end

endmodule : apc_skid2

// ### apc_ctrl.sv
// Attribute palette controller: host port registers and pixel colour path
// How it works
// - Reading the input status port resets the toggle to the index register.
// - Each write to the write port flips the toggle; read-port reads never do.
// - Host writes an index first; the next write-port write loads that data register.
// - Read port returns the index while it is selected; index taken on write port.
// - Index bit 5 low blanks colour out and opens palette access; high runs translation.
// - Index bits 4:0 choose the data register; bits 7:6 reserved.
// - Sixteen 6-bit palette entries give colour bits 5:0 per pixel value except in 256 mode.
// - Mode bit 7 picks colour bits 5:4 from palette or colour select 1:0 except in 256 mode.
// - Mode bit 6 halves the pixel clock enable for 256-colour width.
// - With mode bit 5, line compare stops panning and CRT bits until vsync.
// - Mode bit 3 makes attribute MSB blink instead of background intensity.
// - Ninth dot of line-graphics codes copies eighth dot or shows background.
// - Border colour drives all eight colour bits during overscan.
// - Disabled colour planes force their pixel bit to zero before palette lookup.
// - Status-mux bits pick which colour-bit pair appears on status bits 5,4.
// - Panning drops leading pixels; amount depends on 9-dot, 8-dot or 256 mode.
// - Colour select bits 3:2 drive colour bits 7:6 except in 256 mode.
// - Status port middle digit is B for mono, D for colour.
// - Data registers are written on the write port and read on the read port.
`timescale 1ns/1ps
module apc_ctrl
  import apc_pkg::*;
(
  input  wire logic        i_clk,          // Dot clock, 125 MHz
  input  wire logic        i_nrst,         // Async reset, low
  // Host I/O port
  input  wire logic [15:0] i_io_addr,      // Port address
  input  wire logic        i_io_wr,        // Write strobe, one cycle
  input  wire logic        i_io_rd,        // Read strobe, one cycle
  input  wire logic [7:0]  i_io_wdata,     // Write data
  output logic [7:0]       o_io_rdata,     // Read data
  output logic             o_io_rvalid,    // Read data valid pulse
  output logic             o_data_sel,     // Toggle: 1 = data register next
  // Neighbouring logic
  input  wire logic        i_misc_color,   // Misc output bit 0
  input  wire logic        i_line_start,   // Start of scan line pulse
  input  wire logic        i_line_compare, // CRT line compare pulse
  input  wire logic        i_vsync,        // Vertical sync
  input  wire logic        i_nine_dot,     // 9-dot character clock
  output logic             o_crt08_hold,   // CRT reg 08 bits 5,6 disabled
  output logic [1:0]       o_status_route, // Input status bits 5,4
  output logic             o_pclk_en,      // Pixel clock enable
  // Pixel stream in
  input  wire logic        i_pix_valid,    // Pixel offered
  input  wire logic [3:0]  i_pix_data,     // Pixel value
  input  wire logic        i_pix_fg,       // Foreground dot
  input  wire logic [3:0]  i_pix_bg,       // Background colour
  input  wire logic        i_attr_msb,     // Attribute byte MSB
  input  wire logic        i_blink_phase,  // Blink phase, 1 = shown
  input  wire logic        i_ninth_dot,    // This is the ninth dot
  input  wire logic        i_line_gfx,     // Line-graphics char code
  input  wire logic        i_pix_border,   // Border/overscan period
  output logic             o_pix_ready,    // Pixel may be taken
  // Colour stream out
  output logic             o_color_valid,  // Colour available
  output logic [7:0]       o_color,        // color_out_bit7..0
  input  wire logic        i_color_ready   // Receiver takes colour
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [5:0] pal_r [16];
  logic [7:0] index_r;
  logic [7:0] mode_r;
  logic [7:0] border_r;
  logic [7:0] plane_r;
  logic [7:0] shift_r;
  logic [7:0] csel_r;
  logic       tog_r;

  function automatic logic is_status_port(input logic [15:0] a, input logic color);
    is_status_port = (a == (color ? APC_PORT_STAT_C : APC_PORT_STAT_M));
  endfunction : is_status_port

  function automatic logic [7:0] reg_mask(input logic [4:0] idx);
    unique case (idx)
      APC_IDX_MODE:   reg_mask = APC_MASK_MODE;
      APC_IDX_BORDER: reg_mask = 8'hFF;
      APC_IDX_PLANE:  reg_mask = APC_MASK_PLANE;
      APC_IDX_SHIFT:  reg_mask = APC_MASK_SHIFT;
      APC_IDX_CSEL:   reg_mask = APC_MASK_CSEL;
      default:        reg_mask = (idx <= APC_IDX_PAL_LAST) ? APC_MASK_PAL : 8'h00;
    endcase
  endfunction : reg_mask

  logic       wr_port;
  logic       rd_port;
  logic       stat_rd;
  logic [4:0] sel;
  logic       pal_open;
  logic [7:0] data_wr;

  assign wr_port  = i_io_wr && (i_io_addr == APC_PORT_WR);
  assign rd_port  = i_io_rd && (i_io_addr == APC_PORT_RD);
  assign stat_rd  = i_io_rd && is_status_port(i_io_addr, i_misc_color);
  assign sel      = index_r[4:0];
  assign pal_open = ~index_r[APC_IDX_PAS_BIT];
  assign data_wr  = i_io_wdata & reg_mask(sel);

  // Index/data toggle; a write's flip wins over a same-cycle status read
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tog_r <= APC_RST_TOGGLE;
    end else if (wr_port) begin
      tog_r <= ~tog_r;
    end else if (stat_rd) begin
      tog_r <= 1'b0;
    end
  end

  // Index register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      index_r <= APC_RST_REG;
    end else if (wr_port && !tog_r) begin
      index_r <= i_io_wdata & APC_MASK_INDEX;
    end
  end

  // Palette entries, host writable only while palette is opened
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < 16; i++) begin
        pal_r[i] <= APC_RST_REG[5:0];
      end
    end else if (wr_port && tog_r && pal_open && sel <= APC_IDX_PAL_LAST) begin
      pal_r[sel[3:0]] <= data_wr[5:0];
    end
  end

  // Control registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_r   <= APC_RST_REG;
      border_r <= APC_RST_REG;
      plane_r  <= APC_RST_PLANE;
      shift_r  <= APC_RST_REG;
      csel_r   <= APC_RST_REG;
    end else if (wr_port && tog_r) begin
      unique case (sel)
        APC_IDX_MODE:   mode_r   <= data_wr;
        APC_IDX_BORDER: border_r <= data_wr;
        APC_IDX_PLANE:  plane_r  <= data_wr;
        APC_IDX_SHIFT:  shift_r  <= data_wr;
        APC_IDX_CSEL:   csel_r   <= data_wr;
        default: ;
      endcase
    end
  end

  // Read port: index while selected, else addressed data register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_io_rdata  <= 8'h00;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rvalid <= rd_port;
      if (rd_port) begin
        if (!tog_r) begin
          o_io_rdata <= index_r;
        end else begin
          unique case (sel)
            APC_IDX_MODE:   o_io_rdata <= mode_r;
            APC_IDX_BORDER: o_io_rdata <= border_r;
            APC_IDX_PLANE:  o_io_rdata <= plane_r;
            APC_IDX_SHIFT:  o_io_rdata <= shift_r;
            APC_IDX_CSEL:   o_io_rdata <= csel_r;
            default: o_io_rdata <= (sel <= APC_IDX_PAL_LAST) ? {2'b00, pal_r[sel[3:0]]} : 8'h00;
          endcase
        end
      end
    end
  end

  assign o_data_sel = tog_r;

  ////////////////////////////////////////////////////////////////////////
  // Pixel clock enable and panning hold

  logic wide;
  logic text;
  logic blink_md;
  logic pan_off_r;

  assign wide     = mode_r[APC_MODE_WIDE_BIT];
  assign text     = ~mode_r[APC_MODE_GFX_BIT];
  assign blink_md = mode_r[APC_MODE_BLINK_BIT];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pclk_en <= 1'b1;
    end else begin
      o_pclk_en <= wide ? ~o_pclk_en : 1'b1;
    end
  end

  // Compare sets, vsync clears; a compare in a vsync cycle wins
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pan_off_r <= 1'b0;
    end else if (i_line_compare && mode_r[APC_MODE_PANC_BIT]) begin
      pan_off_r <= 1'b1;
    end else if (i_vsync || !mode_r[APC_MODE_PANC_BIT]) begin
      pan_off_r <= 1'b0;
    end
  end

  assign o_crt08_hold = pan_off_r;

  ////////////////////////////////////////////////////////////////////////
  // Pixel path

  logic [3:0] skip_r;
  logic [3:0] pan_amt;
  logic [3:0] skip_now;
  logic       half_r;
  logic [3:0] first_r;
  logic [3:0] last_r;
  logic [3:0] bgx;
  logic [3:0] base;
  logic [3:0] masked;
  logic [5:0] pal;
  logic [7:0] color;
  logic       fifo_rdy;
  logic       take;
  logic       drop;
  logic       push;

  always_comb begin
    if (pan_off_r) begin
      pan_amt = 4'h0;
    end else if (wide) begin
      pan_amt = {2'b00, shift_r[2:1]};
    end else if (i_nine_dot) begin
      pan_amt = (shift_r[3:0] < APC_PAN_NINE_WRAP) ? shift_r[3:0] + 4'h1 : 4'h0;
    end else begin
      pan_amt = {1'b0, shift_r[2:0]};
    end
  end

  assign skip_now = i_line_start ? pan_amt : skip_r;
  assign take     = i_pix_valid && fifo_rdy && o_pclk_en;
  assign drop     = (skip_now != 4'h0);
  assign push     = take && !drop && (!wide || half_r);

  always_comb begin
    bgx  = (text && blink_md) ? {1'b0, i_pix_bg[2:0]} : i_pix_bg;
    base = i_pix_data;
    if (text) begin
      if (!i_pix_fg) begin
        base = bgx;
      end else if (blink_md && i_attr_msb && !i_blink_phase) begin
        base = bgx;
      end
    end
    if (text && i_ninth_dot && i_line_gfx) begin
      base = mode_r[APC_MODE_LGFX_BIT] ? last_r : bgx;
    end
  end

  assign masked = base & plane_r[3:0];
  assign pal    = pal_r[masked];

  always_comb begin
    if (pal_open) begin
      color = 8'h00;
    end else if (i_pix_border) begin
      color = border_r;
    end else if (wide) begin
      color = {first_r, masked};
    end else begin
      color = {csel_r[3:2],
               mode_r[APC_MODE_C54_BIT] ? csel_r[1:0] : pal[5:4],
               pal[3:0]};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      skip_r  <= 4'h0;
      half_r  <= 1'b0;
      first_r <= 4'h0;
      last_r  <= 4'h0;
    end else begin
      if (take) begin
        skip_r <= drop ? skip_now - 4'h1 : 4'h0;
        if (!drop) begin
          last_r <= base;
          half_r <= wide & ~half_r;
          if (!half_r) begin
            first_r <= masked;
          end
        end
      end else if (i_line_start) begin
        skip_r <= pan_amt;
        half_r <= 1'b0;
      end
    end
  end

  // Status bits follow the last colour pushed out
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status_route <= 2'b00;
    end else if (push) begin
      unique case (apc_route_t'(plane_r[5:4]))
        APC_RT_20: o_status_route <= {color[2], color[0]};
        APC_RT_54: o_status_route <= {color[5], color[4]};
        APC_RT_31: o_status_route <= {color[3], color[1]};
        APC_RT_76: o_status_route <= {color[7], color[6]};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffer

  apc_skid2 #(
    .W (8)
  ) u_buf (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (push),
    .i_in_data   (color),
    .o_in_ready  (fifo_rdy),
    .o_out_valid (o_color_valid),
    .o_out_data  (o_color),
    .i_out_ready (i_color_ready)
  );

  assign o_pix_ready = fifo_rdy;

endmodule : apc_ctrl

// ### apc_ctrl_props.sv
// Concurrent checks on the attribute palette controller ports
`timescale 1ns/1ps
module apc_ctrl_props
  import apc_pkg::*;
(
  input wire logic        i_clk,          // Dot clock
  input wire logic        i_nrst,         // Async reset, low
  input wire logic [15:0] i_io_addr,      // Port address
  input wire logic        i_io_wr,        // Write strobe
  input wire logic        i_io_rd,        // Read strobe
  input wire logic        i_misc_color,   // Colour addressing
  input wire logic        i_line_compare, // Line compare hit
  input wire logic        i_vsync,        // Vertical sync
  input wire logic        i_color_ready,  // Colour taken
  input wire logic [7:0]  o_io_rdata,     // Read data
  input wire logic        o_io_rvalid,    // Read data valid
  input wire logic        o_data_sel,     // Toggle state
  input wire logic        o_crt08_hold,   // Panning hold
  input wire logic        o_pclk_en,      // Pixel clock enable
  input wire logic        o_color_valid,  // Colour available
  input wire logic [7:0]  o_color         // Colour word
);
  logic wr_port;
  logic rd_port;
  logic rd_stat;

  assign wr_port = i_io_wr && (i_io_addr == APC_PORT_WR);
  assign rd_port = i_io_rd && (i_io_addr == APC_PORT_RD);
  assign rd_stat = i_io_rd && (i_io_addr == (i_misc_color ? APC_PORT_STAT_C : APC_PORT_STAT_M));

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  ////////////////////////////////////////
  a_read_answers: assert property (rd_port |=> o_io_rvalid)
    else $error("no read answer");
  a_answer_cause: assert property (o_io_rvalid |-> $past(rd_port))
    else $error("read answer without read");
  a_rdata_holds: assert property (!o_io_rvalid |-> $stable(o_io_rdata))
    else $error("read data moved");
  a_write_flips: assert property (wr_port |=> o_data_sel != $past(o_data_sel))
    else $error("write did not flip toggle");
  a_read_keeps: assert property (rd_port |=> $stable(o_data_sel))
    else $error("read flipped toggle");
  a_status_clears: assert property (rd_stat |=> !o_data_sel)
    else $error("status read kept toggle");
  a_pclk_no_gap: assert property (!o_pclk_en |=> o_pclk_en)
    else $error("pixel clock below half rate");
  a_hold_vsync: assert property ((i_vsync && !i_line_compare) |=> !o_crt08_hold)
    else $error("hold survived vsync");
  a_hold_cause: assert property ($rose(o_crt08_hold) |-> $past(i_line_compare))
    else $error("hold without compare");
  a_color_stall: assert property ((o_color_valid && !i_color_ready) |=> o_color_valid && $stable(o_color))
    else $error("stalled colour lost");
endmodule : apc_ctrl_props

bind apc_ctrl apc_ctrl_props chk_u (.*);

// ### apc_host_model.sv
// Host processor model on the I/O port bus
`timescale 1ns/1ps
module apc_host_model
  import apc_pkg::*;
(
  input  wire logic       i_clk,   // Dot clock
  input  wire logic       i_misc,  // Colour addressing
  output logic [15:0]     o_addr,  // Port address
  output logic            o_wr,    // Write strobe
  output logic            o_rd,    // Read strobe
  output logic [7:0]      o_wdata, // Write data
  input  wire logic [7:0] i_rdata, // Read data
  input  wire logic       i_rvalid // Read data valid
);
  initial begin
    o_addr  = 16'hFFFF;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // Released bus shows inverted values, never stale ones
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_clk);
    o_rd   = 1'b0;
    o_addr = ~a;
    d      = i_rdata;
    v      = i_rvalid;
  endtask : rd

  // Status read first so the next write is an index
  task automatic wrreg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    logic       v;
    rd(i_misc ? APC_PORT_STAT_C : APC_PORT_STAT_M, x, v);
    wr(APC_PORT_WR, idx);
    wr(APC_PORT_WR, d);
  endtask : wrreg

  task automatic rdreg(input logic [7:0] idx, output logic [7:0] d);
    logic v;
    rd(i_misc ? APC_PORT_STAT_C : APC_PORT_STAT_M, d, v);
    wr(APC_PORT_WR, idx);
    rd(APC_PORT_RD, d, v);
  endtask : rdreg
endmodule : apc_host_model

// ### test_apc_ctrl.sv
// Self-checking bench for the attribute palette controller
`timescale 1ns/1ps
module test_apc_ctrl
  import apc_pkg::*;
;
  logic        i_clk = 1'b0, i_nrst = 1'b0, i_io_wr, i_io_rd, o_io_rvalid, o_data_sel, rv;
  logic        o_crt08_hold, o_pclk_en, o_pix_ready, o_color_valid;
  logic        i_misc_color = 1'b1, i_line_start = 1'b0, i_line_compare = 1'b0, i_vsync = 1'b0;
  logic        i_nine_dot = 1'b0, i_pix_valid = 1'b0, i_pix_fg = 1'b1, i_attr_msb = 1'b0;
  logic        i_blink_phase = 1'b1, i_ninth_dot = 1'b0, i_line_gfx = 1'b0, i_pix_border = 1'b0;
  logic        i_color_ready = 1'b1;
  logic [15:0] i_io_addr;
  logic [7:0]  i_io_wdata, o_io_rdata, o_color, rb;
  logic [3:0]  i_pix_data = 4'h0, i_pix_bg = 4'h0;
  logic [1:0]  o_status_route;
  logic [7:0]  got[$];
  logic [7:0]  msk[5] = '{APC_MASK_MODE, 8'hFF, APC_MASK_PLANE, APC_MASK_SHIFT, APC_MASK_CSEL};
  int          mismatches = 0;
  int          samples_checked = 0;

  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_color_valid && i_color_ready) got.push_back(o_color);

  apc_ctrl dut_u (.*);
  apc_host_model host_u (.i_clk(i_clk), .i_misc(i_misc_color), .o_addr(i_io_addr), .o_wr(i_io_wr),
                         .o_rd(i_io_rd), .o_wdata(i_io_wdata), .i_rdata(o_io_rdata), .i_rvalid(o_io_rvalid));

  ////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  function automatic logic [7:0] col(input logic [3:0] i);
    return {2'b11, i[1:0], i};
  endfunction : col

  task automatic push(input logic [3:0] p);
    int n;
    n = 0;
    @(negedge i_clk);
    i_pix_data  = p;
    i_pix_valid = 1'b1;
    while (!(o_pix_ready && o_pclk_en) && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge i_clk);
    i_pix_valid = 1'b0;
  endtask : push

  task automatic expect_col(input logic [7:0] e);
    int n;
    n = 0;
    while (got.size() == 0 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk((got.size() > 0) ? got.pop_front() : 8'hXX, e, "colour");
  endtask : expect_col

  task automatic pulse_line;
    @(negedge i_clk);
    i_line_start = 1'b1;
    @(negedge i_clk);
    i_line_start = 1'b0;
  endtask : pulse_line

  task automatic run_pix(input logic [7:0] md, pl, input logic [3:0] p, bg, input logic fg, msb, blk, nin, lg,
                         input logic brd, input logic [7:0] e);
    logic [1:0] r;
    host_u.wrreg(8'h30, md);
    host_u.wrreg(8'h32, pl);
    {i_pix_bg, i_pix_fg, i_attr_msb, i_blink_phase} = {bg, fg, msb, blk};
    {i_ninth_dot, i_line_gfx, i_pix_border} = {nin, lg, brd};
    got.delete();
    push(p);
    expect_col(e);
    case (pl[5:4])
      2'b00: r = {e[2], e[0]};
      2'b01: r = {e[5], e[4]};
      2'b10: r = {e[3], e[1]};
      default: r = {e[7], e[6]};
    endcase
    chk({6'h0, o_status_route}, {6'h0, r}, "route");
  endtask : run_pix

  task automatic pan(input logic [7:0] sh, input logic nine, input int drop);
    host_u.wrreg(8'h33, sh);
    host_u.wrreg(8'h30, 8'h01);
    i_nine_dot = nine;
    pulse_line();
    got.delete();
    for (int k = 0; k <= drop; k++) push(4'(k + 1));
    expect_col(col(4'(drop + 1)));
  endtask : pan

  ////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    chk({3'h0, o_data_sel, o_io_rvalid, o_color_valid, o_pix_ready, o_pclk_en}, 8'h03, "reset");
    for (int i = 16; i < 21; i++) begin
      host_u.rdreg(8'(i), rb);
      chk(rb, (i == 18) ? APC_RST_PLANE : APC_RST_REG, "reset reg");
    end
    for (int i = 0; i < 22; i++) begin
      host_u.wrreg(8'(i), (i < 16) ? {2'b11, i[1:0], i[3:0]} : 8'hFF);
      host_u.rdreg(8'(i), rb);
      chk(rb, (i < 16) ? {2'b00, i[1:0], i[3:0]} : (i < 21) ? msk[i - 16] : 8'h00, "reg");
    end
    host_u.wrreg(8'h25, 8'h00);
    host_u.rdreg(8'h25, rb);
    chk(rb, 8'h15, "palette locked");
    host_u.wrreg(8'h31, 8'h5A);
    host_u.wrreg(8'h34, 8'h0C);
    i_misc_color = 1'b0;
    host_u.wr(APC_PORT_WR, 8'hF1);
    chk({7'h0, o_data_sel}, 8'h01, "toggle");
    host_u.rd(APC_PORT_RD, rb, rv);
    chk({7'h0, o_data_sel}, 8'h01, "toggle");
    host_u.rd(APC_PORT_STAT_C, rb, rv);
    chk({7'h0, o_data_sel}, 8'h01, "toggle");
    host_u.rd(APC_PORT_STAT_M, rb, rv);
    chk({7'h0, o_data_sel}, 8'h00, "toggle");
    i_misc_color = 1'b1;
    host_u.wr(APC_PORT_WR, 8'hF3);
    host_u.wr(APC_PORT_WR, 8'h0F);
    chk({7'h0, o_data_sel}, 8'h00, "toggle");
    host_u.rd(APC_PORT_RD, rb, rv);
    chk({rv, rb[6:0]}, 8'hB3, "index read");
    host_u.wr(APC_PORT_WR, 8'h20);
    host_u.rd(APC_PORT_STAT_C, rb, rv);
    chk({7'h0, o_data_sel}, 8'h00, "toggle");
    run_pix(8'h01, 8'h0F, 4'h5, 4'h0, 1, 0, 1, 0, 0, 0, col(4'h5));
    run_pix(8'h81, 8'h1F, 4'h5, 4'h0, 1, 0, 1, 0, 0, 0, 8'hC5);
    run_pix(8'h01, 8'h2E, 4'h5, 4'h0, 1, 0, 1, 0, 0, 0, col(4'h4));
    run_pix(8'h01, 8'h3F, 4'h5, 4'h0, 1, 0, 1, 0, 0, 1, 8'h5A);
    run_pix(8'h08, 8'h0F, 4'h7, 4'hB, 1, 1, 0, 0, 0, 0, col(4'h3));
    run_pix(8'h00, 8'h0F, 4'h7, 4'hB, 1, 1, 0, 0, 0, 0, col(4'h7));
    run_pix(8'h00, 8'h0F, 4'h7, 4'hB, 0, 0, 1, 0, 0, 0, col(4'hB));
    run_pix(8'h00, 8'h0F, 4'h6, 4'h2, 1, 0, 1, 1, 1, 0, col(4'h2));
    run_pix(8'h04, 8'h0F, 4'h9, 4'h2, 1, 0, 1, 0, 0, 0, col(4'h9));
    run_pix(8'h04, 8'h0F, 4'h6, 4'h2, 1, 0, 1, 1, 1, 0, col(4'h9));
    {i_ninth_dot, i_line_gfx} = 2'b00;
    host_u.wrreg(8'h00, 8'h00);
    got.delete();
    push(4'h5);
    expect_col(8'h00);
    pan(8'h00, 1'b1, 1);
    pan(8'h07, 1'b1, 8);
    pan(8'h08, 1'b1, 0);
    pan(8'h03, 1'b0, 3);
    pan(8'h07, 1'b0, 7);
    host_u.wrreg(8'h30, 8'h21);
    @(negedge i_clk);
    i_line_compare = 1'b1;
    @(negedge i_clk);
    i_line_compare = 1'b0;
    chk({7'h0, o_crt08_hold}, 8'h01, "hold");
    pulse_line();
    got.delete();
    push(4'h1);
    expect_col(col(4'h1));
    @(negedge i_clk);
    i_vsync = 1'b1;
    @(negedge i_clk);
    i_vsync = 1'b0;
    chk({7'h0, o_crt08_hold}, 8'h00, "hold");
    host_u.wrreg(8'h33, 8'h00);
    host_u.wrreg(8'h30, 8'h41);
    @(negedge i_clk);
    rv = o_pclk_en;
    @(negedge i_clk);
    chk({7'h0, o_pclk_en}, {7'h0, ~rv}, "pixel clock");
    pulse_line();
    got.delete();
    push(4'hA);
    push(4'h5);
    expect_col(8'hA5);
    host_u.wrreg(8'h30, 8'h01);
    i_color_ready = 1'b0;
    got.delete();
    push(4'h1);
    push(4'h2);
    chk({7'h0, o_pix_ready}, 8'h00, "buffer full");
    i_color_ready = 1'b1;
    expect_col(col(4'h1));
    expect_col(col(4'h2));
    final_report();
  end
endmodule : test_apc_ctrl
